/* src/mfc_pkg.sv */
// constants, types and crc helper for the flow control and rx filter block
// Operation
// - full duplex mode 11: send one pause frame with zero timer, then off
// - full duplex mode 10: send pause frames periodically until software changes
// - full duplex mode 01 sends one pause frame then clears; 00 is off
// - half duplex: only the low mode bit matters, high bit ignored
// - mode register bits 7:2 read zero; mode bits reset to zero
// - pause timer is 16 bits, low and high byte both writable
// - combine bit picks AND of enabled filters or OR of them
// - filter control 20h checks only crc: promiscuous reception
// - unicast passes only if all six address bytes equal station address
// - multicast passes when bit 0 of first address byte is one
// - broadcast passes when the address is all ones
// - hash computes a 32-bit crc over the six address bytes
// - crc bits 28:23 form the six-bit hash index
// - hash passes when the indexed table bit is set
// - index bits 5:3 pick the table byte, bits 2:0 the bit
// - empty table never matches, full table always matches
// - pause frame waits for any transmission in progress to finish
// - half duplex flow on jams the medium with 55h until off
// - pause frame is 64 bytes to 01-80-c2-00-00-01 with timer, pad, crc
package mfc_pkg;
	localparam int CLK_MHZ = 100;
	localparam logic [7:0] A_FLOW = 8'h00;
	localparam logic [7:0] A_MAC3 = 8'h04;
	localparam logic [7:0] A_PLO = 8'h08;
	localparam logic [7:0] A_PHI = 8'h0c;
	localparam logic [7:0] A_FILT = 8'h10;
	localparam logic [7:0] A_STAT = 8'h14;
	localparam logic [7:0] A_STA0 = 8'h20;
	localparam logic [7:0] A_HASH0 = 8'h40;
	localparam int FDX_BIT = 0;
	localparam int F_UC = 7;
	localparam int F_FILTER_COMBINE_SELECT = 6;
	localparam int F_CRC = 5;
	localparam int F_PM = 4;
	localparam int F_MP = 3;
	localparam int F_HT = 2;
	localparam int F_MC = 1;
	localparam int F_BC = 0;
	localparam logic [1:0] RST_MODE = 2'h0;
	localparam logic [7:0] RST_FILT = 8'ha1;
	localparam logic [1:0] M_OFF = 2'h0;
	localparam logic [1:0] M_ONE = 2'h1;
	localparam logic [1:0] M_REP = 2'h2;
	localparam logic [1:0] M_ZERO = 2'h3;
	localparam logic [7:0] JAM_BYTE = 8'h55;
	localparam logic [47:0] PAUSE_DA = 48'h0180c2000001;
	localparam logic [15:0] PAUSE_TYPE = 16'h8808;
	localparam logic [15:0] PAUSE_OP = 16'h0001;
	localparam logic [6:0] PAUSE_LEN = 7'h40;
	localparam logic [6:0] FCS_POS = 7'h3c;
	localparam logic [31:0] CRC_POLY = 32'h04c11db7;
	localparam logic [31:0] CRC_INIT = 32'hffffffff;
	localparam int HASH_HI = 28;
	localparam int HASH_LO = 23;
	localparam int REPEAT_NS = 10000;
	localparam int REPEAT_CYC = REPEAT_NS * CLK_MHZ / 1000;
	typedef enum {TX_IDLE, TX_WAIT, TX_SEND} mfc_tx_t;
	// bits enter lsb first, register kept msb aligned
	function automatic logic [31:0] mfc_crc_byte(input logic [31:0] c,
		input logic [7:0] d);
		logic [31:0] r;
		r = c;
		for (int i = 0; i < 8; i++) begin
			r = (r[31] ^ d[i]) ? ((r << 1) ^ CRC_POLY) : (r << 1);
		end
		return r;
	endfunction : mfc_crc_byte
endpackage : mfc_pkg

/* src/mfc_top.sv */
// flow control requests and receive address filters behind an apb slave
//
// The APB interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module mfc_top (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rx_valid,
	input wire logic rx_sof,
	input wire logic [7:0] rx_data,
	input wire logic rx_eof,
	input wire logic rx_crc_ok,
	output logic rx_accept,
	output logic rx_discard,
	input wire logic tx_busy,
	input wire logic pause_ready,
	output logic pause_valid,
	output logic [7:0] pause_data,
	output logic pause_last,
	output logic jam_active,
	output logic [7:0] jam_data
);
	import mfc_pkg::*;

	////////////////////////////////////////////////////////////////////////
	logic [1:0] fc_mode;
	logic fdx;
	logic [7:0] ptim_lo, ptim_hi, filt;
	logic [7:0] station [6];
	logic [7:0] hash [8];
	logic [63:0] hash_vec;
	logic wr, hw_clear, last_ok;
	logic [7:0] rd_val;
	logic rd_hit;
	mfc_tx_t state;

	for (genvar g = 0; g < 8; g++) begin : g_hash
		assign hash_vec[g*8 +: 8] = hash[g];
	end

	// write lands on the edge that completes the access
	assign wr = psel & penable & pwrite & pready;

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end else begin
			pready <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & ~rd_hit;
			prdata <= {24'h0, rd_val};
		end
	end

	always_comb begin
		rd_val = 8'h00;
		rd_hit = 1'b1;
		case (paddr)
			A_FLOW: rd_val = {6'h00, fc_mode};
			A_MAC3: rd_val = {7'h00, fdx};
			A_PLO: rd_val = ptim_lo;
			A_PHI: rd_val = ptim_hi;
			A_FILT: rd_val = filt;
			A_STAT: rd_val = {5'h00, last_ok, jam_active, state != TX_IDLE};
			default: rd_hit = 1'b0;
		endcase
		for (int i = 0; i < 6; i++) begin
			if (paddr == A_STA0 + 8'(4 * i)) begin
				rd_val = station[i];
				rd_hit = 1'b1;
			end
		end
		for (int i = 0; i < 8; i++) begin
			if (paddr == A_HASH0 + 8'(4 * i)) begin
				rd_val = hash[i];
				rd_hit = 1'b1;
			end
		end
	end

	// a software write in the clearing cycle wins: it is the newer request
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			fc_mode <= RST_MODE;
		end else if (wr && paddr == A_FLOW) begin
			fc_mode <= pwdata[1:0];
		end else if (hw_clear) begin
			fc_mode <= M_OFF;
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			fdx <= 1'b0;
			ptim_lo <= 8'h00;
			ptim_hi <= 8'h00;
			filt <= RST_FILT;
			for (int i = 0; i < 6; i++) station[i] <= 8'h00;
			for (int i = 0; i < 8; i++) hash[i] <= 8'h00;
		end else if (wr) begin
			if (paddr == A_MAC3) fdx <= pwdata[FDX_BIT];
			if (paddr == A_PLO) ptim_lo <= pwdata[7:0];
			if (paddr == A_PHI) ptim_hi <= pwdata[7:0];
			if (paddr == A_FILT) filt <= pwdata[7:0];
			for (int i = 0; i < 6; i++) begin
				if (paddr == A_STA0 + 8'(4 * i)) station[i] <= pwdata[7:0];
			end
			for (int i = 0; i < 8; i++) begin
				if (paddr == A_HASH0 + 8'(4 * i)) hash[i] <= pwdata[7:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// receive filters
	logic [7:0] snap_filt;
	logic [7:0] snap_sta [6];
	logic [63:0] snap_hash;
	logic [2:0] da_pos, cur_pos;
	logic in_frame, uc_ok, bc_ok, mc_ok, da_take, pass;
	logic [31:0] rx_crc;
	logic [7:0] sta_cur;
	logic [5:0] hidx;
	logic da_full, ht_ok, any_en, or_hit, and_ok;

	assign cur_pos = rx_sof ? 3'd0 : da_pos;
	assign da_take = rx_valid & (rx_sof | (in_frame & da_pos != 3'd6));
	assign sta_cur = rx_sof ? station[cur_pos] : snap_sta[cur_pos];

	// snapshot keeps a mid-frame register write out of this frame
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			snap_filt <= RST_FILT;
			snap_hash <= 64'h0;
			for (int i = 0; i < 6; i++) snap_sta[i] <= 8'h00;
		end else if (rx_valid && rx_sof) begin
			snap_filt <= filt;
			snap_hash <= hash_vec;
			for (int i = 0; i < 6; i++) snap_sta[i] <= station[i];
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			in_frame <= 1'b0;
			da_pos <= 3'd6;
			uc_ok <= 1'b0;
			bc_ok <= 1'b0;
			mc_ok <= 1'b0;
			rx_crc <= CRC_INIT;
		end else begin
			if (rx_valid && rx_sof) begin
				in_frame <= 1'b1;
			end else if (rx_eof) begin
				in_frame <= 1'b0;
			end
			if (da_take) begin
				da_pos <= cur_pos + 3'd1;
				uc_ok <= (rx_sof | uc_ok) & (rx_data == sta_cur);
				bc_ok <= (rx_sof | bc_ok) & (rx_data == 8'hff);
				if (rx_sof) mc_ok <= rx_data[0];
				rx_crc <= mfc_crc_byte(rx_sof ? CRC_INIT : rx_crc, rx_data);
			end
		end
	end

	assign da_full = da_pos == 3'd6;
	assign hidx = rx_crc[HASH_HI:HASH_LO];
	assign ht_ok = da_full & snap_hash[hidx];
	// pattern and wake filters are absent here: they never accept
	assign any_en = |{snap_filt[F_UC], snap_filt[F_PM], snap_filt[F_MP],
		snap_filt[F_HT], snap_filt[F_MC], snap_filt[F_BC]};
	assign or_hit = (snap_filt[F_UC] & da_full & uc_ok)
		| (snap_filt[F_HT] & ht_ok)
		| (snap_filt[F_MC] & mc_ok)
		| (snap_filt[F_BC] & da_full & bc_ok);
	assign and_ok = (~snap_filt[F_UC] | (da_full & uc_ok))
		& ~snap_filt[F_PM] & ~snap_filt[F_MP]
		& (~snap_filt[F_HT] | ht_ok)
		& (~snap_filt[F_MC] | mc_ok)
		& (~snap_filt[F_BC] | (da_full & bc_ok));
	// no filter enabled, pattern and wake included, admits all: promiscuous with crc only
	assign pass = (snap_filt[F_FILTER_COMBINE_SELECT] ? and_ok : (~any_en | or_hit))
		& (~snap_filt[F_CRC] | rx_crc_ok);

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			rx_accept <= 1'b0;
			rx_discard <= 1'b0;
			last_ok <= 1'b0;
		end else begin
			rx_accept <= in_frame & rx_eof & pass;
			rx_discard <= in_frame & rx_eof & ~pass;
			if (in_frame && rx_eof) last_ok <= pass;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pause frame generator and half duplex jam
	logic [6:0] tx_cnt;
	logic [31:0] tx_crc, fcs_inv;
	logic [15:0] ptim_snap, rep_cnt;
	logic send_zero, one_shot, want, load, done;
	logic [7:0] nb, fcs_b;

	assign want = fdx & (fc_mode == M_ONE | fc_mode == M_ZERO
		| (fc_mode == M_REP & rep_cnt == 16'h0));
	assign load = state == TX_SEND & (~pause_valid | pause_ready);
	assign done = load & tx_cnt == PAUSE_LEN;
	assign fcs_inv = ~tx_crc;

	always_comb begin
		fcs_b = 8'h00;
		for (int i = 0; i < 8; i++) begin
			fcs_b[i] = fcs_inv[31 - 8 * tx_cnt[1:0] - i];
		end
		if (tx_cnt < 7'd6) nb = PAUSE_DA[47 - 8 * tx_cnt[2:0] -: 8];
		else if (tx_cnt < 7'd12) nb = station[3'(tx_cnt - 7'd6)];
		else if (tx_cnt == 7'd12) nb = PAUSE_TYPE[15:8];
		else if (tx_cnt == 7'd13) nb = PAUSE_TYPE[7:0];
		else if (tx_cnt == 7'd14) nb = PAUSE_OP[15:8];
		else if (tx_cnt == 7'd15) nb = PAUSE_OP[7:0];
		else if (tx_cnt == 7'd16) nb = ptim_snap[15:8];
		else if (tx_cnt == 7'd17) nb = ptim_snap[7:0];
		else if (tx_cnt < FCS_POS) nb = 8'h00;
		else nb = fcs_b;
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			state <= TX_IDLE;
			tx_cnt <= 7'h0;
			tx_crc <= CRC_INIT;
			ptim_snap <= 16'h0;
			send_zero <= 1'b0;
			one_shot <= 1'b0;
		end else begin
			case (state)
				TX_IDLE: if (want) begin
					state <= TX_WAIT;
					send_zero <= fc_mode == M_ZERO;
					one_shot <= fc_mode[0];
				end
				TX_WAIT: if (!tx_busy) begin
					state <= TX_SEND;
					tx_cnt <= 7'h0;
					tx_crc <= CRC_INIT;
					ptim_snap <= send_zero ? 16'h0 : {ptim_hi, ptim_lo};
				end
				TX_SEND: if (done) begin
					state <= TX_IDLE;
				end else if (load) begin
					tx_cnt <= tx_cnt + 7'h1;
					if (tx_cnt < FCS_POS) tx_crc <= mfc_crc_byte(tx_crc, nb);
				end
				default: state <= TX_IDLE;
			endcase
		end
	end

	assign hw_clear = done & one_shot;

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			pause_valid <= 1'b0;
			pause_data <= 8'h00;
			pause_last <= 1'b0;
		end else if (done) begin
			pause_valid <= 1'b0;
			pause_last <= 1'b0;
		end else if (load) begin
			pause_valid <= 1'b1;
			pause_data <= nb;
			pause_last <= tx_cnt == PAUSE_LEN - 7'h1;
		end
	end

	// repeat spacing for periodic mode; restarts after each frame
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			rep_cnt <= 16'h0;
		end else if (done) begin
			rep_cnt <= 16'(REPEAT_CYC - 1);
		end else if (rep_cnt != 16'h0 && state == TX_IDLE) begin
			rep_cnt <= rep_cnt - 16'h1;
		end
	end

	// jam pauses while the mac sends its own packet, then resumes
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			jam_active <= 1'b0;
			jam_data <= 8'h00;
		end else begin
			jam_active <= ~fdx & fc_mode[0] & ~tx_busy;
			jam_data <= JAM_BYTE;
		end
	end

	////////////////////////////////////////////////////////////////////////
	sequence s_last_load;
		load && tx_cnt == PAUSE_LEN - 7'h1;
	endsequence

	sequence s_done_clear;
		done && one_shot && !(wr && paddr == A_FLOW);
	endsequence

	a_oneshot_clears: assert property (@(posedge core_clk) disable iff (!resetn)
		s_done_clear |=> fc_mode == M_OFF && state == TX_IDLE)
		else $error("one-shot mode not cleared");
	a_periodic_holds: assert property (@(posedge core_clk) disable iff (!resetn)
		done && fc_mode == M_REP && !wr |=> fc_mode == M_REP && rep_cnt != 16'h0)
		else $error("periodic mode lost");
	a_zero_timer: assert property (@(posedge core_clk) disable iff (!resetn)
		load && send_zero && (tx_cnt == 7'd16 || tx_cnt == 7'd17)
		|=> pause_data == 8'h00)
		else $error("zero pause timer not sent");
	a_wait_busy: assert property (@(posedge core_clk) disable iff (!resetn)
		state == TX_WAIT && tx_busy |=> state == TX_WAIT && !pause_valid)
		else $error("pause sent during transmission");
	a_frame_end: assert property (@(posedge core_clk) disable iff (!resetn)
		s_last_load |=> pause_last && pause_valid)
		else $error("pause frame end wrong");
	a_frame_close: assert property (@(posedge core_clk) disable iff (!resetn)
		done |=> !pause_valid && !pause_last && state == TX_IDLE)
		else $error("pause frame not closed");
	a_jam_half: assert property (@(posedge core_clk) disable iff (!resetn)
		!fdx && fc_mode[0] && !tx_busy |=> jam_active && jam_data == JAM_BYTE)
		else $error("half duplex jam missing");
	a_promisc_all: assert property (@(posedge core_clk) disable iff (!resetn)
		in_frame && rx_eof && snap_filt == 8'h20 && rx_crc_ok |=> rx_accept)
		else $error("promiscuous frame dropped");
	a_hash_empty: assert property (@(posedge core_clk) disable iff (!resetn)
		in_frame && rx_eof && snap_hash == 64'h0 && snap_filt == 8'h44
		|=> rx_discard && !rx_accept)
		else $error("empty hash table matched");
	a_da_first: assert property (@(posedge core_clk) disable iff (!resetn)
		load && tx_cnt == 7'h0 |=> pause_data == PAUSE_DA[47:40] && pause_valid)
		else $error("pause destination wrong");
endmodule : mfc_top
`default_nettype wire

/* tb/mfc_pause_sink.sv */
// pause frame sink standing in for the transmit path behind the block
`timescale 1ns/1ns
`default_nettype none
module mfc_pause_sink (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic slow,
	input wire logic pause_valid,
	input wire logic [7:0] pause_data,
	input wire logic pause_last,
	output logic pause_ready,
	output logic [7:0] n_frames,
	output logic [511:0] fb,
	output logic [5:0] last_idx
);
	logic [5:0] idx;
	logic tog;
	// slow takes a byte every other cycle so held bytes get exercised
	assign pause_ready = slow ? tog : 1'b1;
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			tog <= 1'b0;
			idx <= 6'h00;
			n_frames <= 8'h00;
			fb <= '0;
			last_idx <= 6'h00;
		end else begin
			tog <= ~tog;
			if (pause_valid && pause_ready) begin
				fb[idx*8 +: 8] <= pause_data;
				idx <= idx + 6'h01;
				if (pause_last) begin
					n_frames <= n_frames + 8'h01;
					last_idx <= idx;
					idx <= 6'h00;
				end
			end
		end
	end
endmodule : mfc_pause_sink
`default_nettype wire

/* tb/test_mfc_top.sv */
// self-checking bench for flow control requests and rx filters
`timescale 1ns/1ns
`default_nettype none
module test_mfc_top;
	import mfc_pkg::*;
	localparam logic [47:0] STA = 48'h021122334455;
	localparam logic [47:0] HDA = 48'h01000000012c;
	logic core_clk = 1'b0;
	logic resetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, err;
	logic rx_valid = 1'b0;
	logic rx_sof = 1'b0;
	logic rx_eof = 1'b0;
	logic rx_crc_ok = 1'b0;
	logic [7:0] rx_data = 8'h00;
	logic tx_busy = 1'b0;
	logic slow = 1'b0;
	logic rx_accept, rx_discard, pause_ready, pause_valid;
	logic pause_last, jam_active;
	logic [7:0] pause_data, jam_data, n_frames;
	logic [511:0] fb;
	logic [5:0] last_idx;
	int fail_count = 0;
	int n_compared = 0;
	mfc_top i_mfc_top (.core_clk, .resetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .rx_valid, .rx_sof,
		.rx_data, .rx_eof, .rx_crc_ok, .rx_accept, .rx_discard, .tx_busy,
		.pause_ready, .pause_valid, .pause_data, .pause_last, .jam_active,
		.jam_data);
	mfc_pause_sink u_sink (.core_clk, .resetn, .slow, .pause_valid,
		.pause_data, .pause_last, .pause_ready, .n_frames, .fb, .last_idx);
	initial begin
		forever #5 core_clk = ~core_clk;
	end
	////////////////////////////////////////////////////////////////////
	task automatic check(input logic [47:0] seen, input logic [47:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic tally_and_finish;
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : tally_and_finish
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [7:0] d);
		int k;
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		penable <= 1'b0;
		@(posedge core_clk);
		penable <= 1'b1;
		for (k = 0; k < 20; k++) begin
			@(posedge core_clk);
			if (pready === 1'b1) break;
		end
		if (k == 20) begin
			fail_count++;
			tally_and_finish();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		apb(1'b0, a, 8'h00);
		check(48'(rd), 48'(e));
	endtask : rchk
	task automatic frame(input logic [47:0] da, input logic ok,
		input logic keep);
		int k;
		for (k = 0; k < 12; k++) begin
			@(posedge core_clk);
			rx_valid <= 1'b1;
			rx_sof <= (k == 0);
			rx_data <= (k < 6) ? da[47-8*k -: 8] : 8'(k);
		end
		@(posedge core_clk);
		rx_valid <= 1'b0;
		rx_sof <= 1'b0;
		rx_eof <= 1'b1;
		rx_crc_ok <= ok;
		@(posedge core_clk);
		rx_eof <= 1'b0;
		for (k = 0; k < 4 && rx_accept !== 1'b1 && rx_discard !== 1'b1; k++)
			@(posedge core_clk);
		check(48'({rx_accept, rx_discard}), keep ? 48'h2 : 48'h1);
	endtask : frame
	task automatic pause_wait(input logic [15:0] tmr, input logic want);
		int k;
		logic [7:0] n0;
		logic [31:0] c;
		n0 = n_frames;
		for (k = 0; k < 3000 && n_frames == n0; k++)
			@(posedge core_clk);
		check(48'(n_frames - n0), 48'(want));
		if (want) begin
			for (k = 0; k < 6; k++) begin
				check(48'(fb[8*k +: 8]), 48'(PAUSE_DA[47-8*k -: 8]));
				check(48'(fb[48+8*k +: 8]), 48'(STA[47-8*k -: 8]));
			end
			check(fb[96 +: 48], {tmr[7:0], tmr[15:8], 32'h01000888});
			check(48'(fb[144 +: 336] == 336'h0), 48'h1);
			check(48'(last_idx), 48'h3f);
			// serial crc over the whole frame, fcs included, leaves the residue
			c = 32'hffffffff;
			for (k = 0; k < 512; k++)
				c = (c[31] ^ fb[k]) ? ((c << 1) ^ CRC_POLY) : (c << 1);
			check(48'(c), 48'hc704dd7b);
		end
	endtask : pause_wait
	////////////////////////////////////////////////////////////////////
	task automatic regs_scn;
		rchk(A_FLOW, 8'h00);
		rchk(A_FILT, RST_FILT);
		apb(1'b1, A_FLOW, 8'hfe);
		rchk(A_FLOW, 8'h02);
		check(48'(jam_active), 48'h0);
		apb(1'b1, A_PLO, 8'h34);
		apb(1'b1, A_PHI, 8'h12);
		rchk(A_PLO, 8'h34);
		rchk(A_PHI, 8'h12);
		apb(1'b0, 8'h80, 8'h00);
		check(48'({err, rd}), 48'h100000000);
	endtask : regs_scn
	task automatic jam_scn;
		apb(1'b1, A_FLOW, 8'h03);
		repeat (3) @(posedge core_clk);
		check(48'({jam_active, jam_data}), 48'h155);
		rchk(A_STAT, 8'h02);
		tx_busy <= 1'b1;
		repeat (3) @(posedge core_clk);
		check(48'(jam_active), 48'h0);
		tx_busy <= 1'b0;
		apb(1'b1, A_FLOW, 8'h00);
		repeat (3) @(posedge core_clk);
		check(48'(jam_active), 48'h0);
	endtask : jam_scn
	task automatic pause_scn;
		for (int k = 0; k < 6; k++)
			apb(1'b1, A_STA0 + 8'(4 * k), STA[47-8*k -: 8]);
		apb(1'b1, A_MAC3, 8'h01);
		tx_busy <= 1'b1;
		apb(1'b1, A_FLOW, 8'h01);
		repeat (20) @(posedge core_clk);
		check(48'(pause_valid), 48'h0);
		tx_busy <= 1'b0;
		slow <= 1'b1;
		pause_wait(16'h1234, 1'b1);
		rchk(A_FLOW, 8'h00);
		slow <= 1'b0;
		apb(1'b1, A_FLOW, 8'h03);
		pause_wait(16'h0000, 1'b1);
		rchk(A_FLOW, 8'h00);
		apb(1'b1, A_FLOW, 8'h02);
		pause_wait(16'h1234, 1'b1);
		pause_wait(16'h1234, 1'b1);
		rchk(A_FLOW, 8'h02);
		apb(1'b1, A_FLOW, 8'h00);
		pause_wait(16'h1234, 1'b0);
	endtask : pause_scn
	task automatic filt_scn;
		apb(1'b1, A_FILT, 8'h20);
		frame(48'h123456789abc, 1'b1, 1'b1);
		frame(48'h123456789abc, 1'b0, 1'b0);
		apb(1'b1, A_FILT, 8'ha0);
		frame(STA, 1'b1, 1'b1);
		frame(STA ^ 48'h1, 1'b1, 1'b0);
		apb(1'b1, A_FILT, 8'h22);
		frame(48'h010000000000, 1'b1, 1'b1);
		frame(48'hfe0000000000, 1'b1, 1'b0);
		apb(1'b1, A_FILT, 8'h21);
		frame(48'hffffffffffff, 1'b1, 1'b1);
		frame(48'hfffffffffffe, 1'b1, 1'b0);
		apb(1'b1, A_FILT, 8'h44);
		frame(HDA, 1'b1, 1'b0);
		apb(1'b1, A_FILT, 8'h24);
		frame(HDA, 1'b1, 1'b0);
		apb(1'b1, A_HASH0 + 8'h18, 8'h10);
		frame(HDA, 1'b1, 1'b1);
		apb(1'b1, A_HASH0 + 8'h18, 8'hef);
		frame(HDA, 1'b1, 1'b0);
		for (int k = 0; k < 8; k++)
			apb(1'b1, A_HASH0 + 8'(4 * k), 8'hff);
		frame(48'h123456789abc, 1'b1, 1'b1);
		apb(1'b1, A_FILT, 8'h63);
		frame(48'hffffffffffff, 1'b1, 1'b1);
		frame(HDA, 1'b1, 1'b0);
		apb(1'b1, A_FILT, 8'h23);
		frame(HDA, 1'b1, 1'b1);
		rchk(A_STAT, 8'h04);
	endtask : filt_scn
	////////////////////////////////////////////////////////////////////
	initial begin
		repeat (5) @(posedge core_clk);
		resetn <= 1'b1;
		regs_scn();
		jam_scn();
		pause_scn();
		filt_scn();
		tally_and_finish();
	end
	initial begin
		repeat (60000) @(posedge core_clk);
		fail_count++;
		tally_and_finish();
	end
endmodule : test_mfc_top
`default_nettype wire
